/* File: include/sfb_pkg.sv */
// Purpose: shared types and constants for the system switch fabric
// Assumes: one fabric clock; every port is synchronous to it
// Notes: slave and master numbering fixes the order of every port array
package sfb_pkg;
	// Fabric geometry
	localparam int MASTER_COUNT = 11;
	localparam int SLAVE_COUNT = 10;
	localparam int DATA_W = 128;
	localparam int CFG_DATA_W = 32;
	localparam int NARROW_DATA_W = 64;
	localparam int ADDR_W = 32;
	localparam int PRIO_W = 3;
	localparam int SLV_ID_W = 4;
	localparam int MST_ID_W = 4;
	// Fabric clock is the CPU clock over this ratio
	localparam int CPU_TO_FABRIC_DIV = 3;

	// Master port numbering
	localparam logic [MST_ID_W-1:0] M_TC0 = 4'h0;
	localparam logic [MST_ID_W-1:0] M_TC5 = 4'h5;
	localparam logic [MST_ID_W-1:0] M_ETHERNET_MAC = 4'h6;
	localparam logic [MST_ID_W-1:0] M_HOST_PORT = 4'h7;
	localparam logic [MST_ID_W-1:0] M_RAPIDIO_DESC = 4'h8;
	localparam logic [MST_ID_W-1:0] M_RAPIDIO_DATA = 4'h9;
	localparam logic [MST_ID_W-1:0] M_CPU = 4'hA;

	// Slave port numbering
	localparam logic [SLV_ID_W-1:0] S_VITERBI = 4'h0;
	localparam logic [SLV_ID_W-1:0] S_TURBO_A = 4'h1;
	localparam logic [SLV_ID_W-1:0] S_TURBO_B = 4'h2;
	localparam logic [SLV_ID_W-1:0] S_SERIAL_PORTS = 4'h3;
	localparam logic [SLV_ID_W-1:0] S_BOOT_ROM = 4'h4;
	localparam logic [SLV_ID_W-1:0] S_UTOPIA = 4'h5;
	localparam logic [SLV_ID_W-1:0] S_CFG_FABRIC = 4'h6;
	localparam logic [SLV_ID_W-1:0] S_DDR2 = 4'h7;
	localparam logic [SLV_ID_W-1:0] S_EXT_MEM_PORT = 4'h8;
	localparam logic [SLV_ID_W-1:0] S_CPU = 4'h9;

	// Connection matrix, bit index is the slave number
	localparam logic [SLAVE_COUNT-1:0] CONN_MATRIX [MASTER_COUNT] = '{
		10'h387, // transfer_controller_0
		10'h39C, // transfer_controller_1
		10'h3F8, // transfer_controller_2
		10'h3E0, // transfer_controller_3
		10'h3C0, // transfer_controller_4
		10'h3C0, // transfer_controller_5
		10'h380, // ethernet_mac
		10'h3C0, // host_port
		10'h3C0, // rapidio_peripheral descriptor
		10'h3C0, // rapidio_peripheral data
		10'h1BF  // cpu subsystem
	};

	// Register windows behind the configuration fabric closed to data masters
	localparam logic [ADDR_W-1:0] DEVCFG_BASE = 32'h0288_0800;
	localparam logic [ADDR_W-1:0] DEVCFG_MASK = 32'hFFFF_FC00;
	localparam logic [ADDR_W-1:0] CLKGEN_BASE = 32'h0290_0000;
	localparam logic [ADDR_W-1:0] CLKGEN_MASK = 32'hFFFF_FC00;

	// Reset values of the port carriers
	localparam logic [DATA_W-1:0] DATA_RESET = 128'h0;

	// Request from a master into the fabric
	typedef struct packed {
		logic valid;
		logic write;
		logic [SLV_ID_W-1:0] slave;
		logic [PRIO_W-1:0] prio;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} sfb_mreq_t;

	// Answer from the fabric to a master
	typedef struct packed {
		logic done;
		logic error;
		logic [DATA_W-1:0] rdata;
	} sfb_mrsp_t;

	// Request from the fabric to a slave
	typedef struct packed {
		logic valid;
		logic write;
		logic [MST_ID_W-1:0] master;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} sfb_sreq_t;

	// Answer from a slave into the fabric
	typedef struct packed {
		logic done;
		logic [DATA_W-1:0] rdata;
	} sfb_srsp_t;
endpackage : sfb_pkg

/* File: hdl/sfb_arbiter.sv */
// Purpose: per-slave arbiter, lowest priority value wins, round robin on ties
// Assumes: eligibility already excludes refused and answered masters
// Notes: a grant stays until the slave reports done
`timescale 1ns/1ps
module sfb_arbiter #(
	parameter int NM = 11,
	parameter int PW = 3
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Requests
	input wire logic [NM-1:0] i_eligible,
	input wire logic [NM-1:0][PW-1:0] i_prio,
	input wire logic i_done,
	// Grant
	output logic [NM-1:0] o_grant,
	output logic [$clog2(NM)-1:0] o_owner
);
	localparam int IW = $clog2(NM);

	// Elaboration check
	if (NM < 2 || PW < 1) begin : g_bad_params
		$error("sfb_arbiter needs at least two masters and one priority bit");
	end

	logic [IW-1:0] ptr;
	logic [NM-1:0] next_cand;
	logic [PW-1:0] next_best;
	logic [IW-1:0] next_pick;
	logic next_found;

	// Best priority value among eligible masters
	always_comb begin
		next_best = '1;
		for (int m = 0; m < NM; m++) begin
			if (i_eligible[m] && i_prio[m] < next_best) begin
				next_best = i_prio[m];
			end
		end
		for (int m = 0; m < NM; m++) begin
			next_cand[m] = i_eligible[m] && (i_prio[m] == next_best);
		end
	end

	// Round robin search starting after the last winner
	always_comb begin
		int idx;
		idx = 0;
		next_found = 1'b0;
		next_pick = '0;
		for (int k = 1; k <= NM; k++) begin
			idx = (int'(ptr) + k) % NM;
			if (!next_found && next_cand[idx]) begin
				next_found = 1'b1;
				next_pick = IW'(idx);
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_grant <= '0;
			o_owner <= '0;
			ptr <= '0;
		end else if (o_grant == '0) begin
			if (next_found) begin
				o_grant <= NM'(1) << next_pick;
				o_owner <= next_pick;
				ptr <= next_pick;
			end
		end else if (i_done) begin
			o_grant <= '0;
		end
	end
endmodule : sfb_arbiter

/* File: hdl/sfb_switch_fabric.sv */
// Purpose: data switch fabric with checked connections and per-slave arbitration
// Assumes: i_clk is the fabric clock; masters hold a request until answered
// Notes: one beat per transfer; width bridges sit on the slave lanes
//
// Operation
// - Data fabric joins masters to slaves over 128-bit buses on fabric clock.
// - Fabric clock for both fabrics is the CPU clock divided by three.
// - Configuration fabric carries CPU register accesses over 32-bit buses.
// - Controllers 0 and 1 reach only their listed slaves.
// - Controllers 2 to 5 reach only their listed slaves.
// - Ethernet, host port and RapidIO reach only memories, CPU, config as listed.
// - CPU master reaches all slaves except config path and itself.
// - RapidIO has separate descriptor and data master connections.
// - Both RapidIO connections obey the same connection limits.
// - Every transfer controller has its own master connection.
// - Data fabric offers a path into the configuration fabric.
// - Bridges convert bus kind, width and clock rate where needed.
// - Full-width fabric-speed peripherals attach directly, others through bridges.
// - External memory port is widened from 64 to 128 bits.
// - Turbo decoders and viterbi take data over a 64-bit configuration bus.
// - External memory port and DDR2 registers sit behind their data bus.
// - Disjoint pairs run concurrently; contending masters are arbitrated.
// - Data-fabric masters may not reach device config or clock registers.
// - Lowest priority value wins among contending masters.
// - Configuration fabric port is a single arbitrated endpoint.
`timescale 1ns/1ps
module sfb_switch_fabric #(
	parameter int NM = sfb_pkg::MASTER_COUNT,
	parameter int NS = sfb_pkg::SLAVE_COUNT
) (
	// Fabric clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Master ports
	input wire sfb_pkg::sfb_mreq_t [NM-1:0] i_mreq,
	output sfb_pkg::sfb_mrsp_t [NM-1:0] o_mrsp,
	// Slave ports
	output sfb_pkg::sfb_sreq_t [NS-1:0] o_sreq,
	input wire sfb_pkg::sfb_srsp_t [NS-1:0] i_srsp
);
	import sfb_pkg::*;

	localparam int IW = $clog2(NM);

	// Elaboration check: the matrix is fixed for this many ports
	if (NM != MASTER_COUNT || NS != SLAVE_COUNT) begin : g_bad_params
		$error("sfb_switch_fabric port counts must match the connection matrix");
	end

	// Lane width seen on a slave side after its bridge
	function automatic logic [DATA_W-1:0] lane_mask(input logic [SLV_ID_W-1:0] slv);
		logic [DATA_W-1:0] mask;
		mask = '1;
		case (slv)
			S_VITERBI, S_TURBO_A, S_TURBO_B: begin
				mask = {{(DATA_W-NARROW_DATA_W){1'b0}}, {NARROW_DATA_W{1'b1}}};
			end
			S_EXT_MEM_PORT: begin
				mask = {{(DATA_W-NARROW_DATA_W){1'b0}}, {NARROW_DATA_W{1'b1}}};
			end
			S_CFG_FABRIC: begin
				mask = {{(DATA_W-CFG_DATA_W){1'b0}}, {CFG_DATA_W{1'b1}}};
			end
			default: begin
				mask = '1;
			end
		endcase
		return mask;
	endfunction : lane_mask

	// Address lies in a window closed to data-fabric masters
	function automatic logic closed_window(input logic [ADDR_W-1:0] addr);
		return ((addr & DEVCFG_MASK) == DEVCFG_BASE) || ((addr & CLKGEN_MASK) == CLKGEN_BASE);
	endfunction : closed_window

	// Registered answers and slave requests
	sfb_mrsp_t mrsp [NM];
	sfb_sreq_t sreq [NS];

	// Decoded master state
	logic [NM-1:0] allowed;
	logic [NM-1:0] refused;
	logic [NS-1:0][NM-1:0] eligible;
	logic [NS-1:0][NM-1:0] grant;
	logic [NS-1:0][IW-1:0] owner;
	logic [NM-1:0][PRIO_W-1:0] prio_vec;

	// Permission per master
	// Each master index is its own port, so controllers and both RapidIO
	// connections are checked independently against their matrix rows.
	// one port per connection
	generate
		for (genvar m = 0; m < NM; m++) begin : g_check
			logic in_range;
			logic row_ok;
			logic cfg_block;
			assign in_range = i_mreq[m].slave < SLV_ID_W'(NS);
			assign row_ok = in_range && CONN_MATRIX[m][i_mreq[m].slave[SLV_ID_W-1:0]];
			assign cfg_block = (i_mreq[m].slave == S_CFG_FABRIC) && closed_window(i_mreq[m].addr);
			assign allowed[m] = i_mreq[m].valid && row_ok && !cfg_block;
			assign refused[m] = i_mreq[m].valid && !(row_ok && !cfg_block);
			assign prio_vec[m] = i_mreq[m].prio;
		end
	endgenerate

	// single fabric clock domain
	// Per-slave arbitration
	// Each slave owns an arbiter, so transfers to different slaves
	// never wait for one another.
	generate
		for (genvar s = 0; s < NS; s++) begin : g_slave
			for (genvar m = 0; m < NM; m++) begin : g_elig
				// Answered masters sit out for the one cycle their done is high
				assign eligible[s][m] = allowed[m] && (i_mreq[m].slave == SLV_ID_W'(s)) && !mrsp[m].done;
			end

			sfb_arbiter #(
				.NM(NM),
				.PW(PRIO_W)
			) u_arb (
				.i_clk(i_clk),
				.i_reset(i_reset),
				.i_eligible(eligible[s]),
				.i_prio(prio_vec),
				.i_done(i_srsp[s].done),
				.o_grant(grant[s]),
				.o_owner(owner[s])
			);

			always_ff @(posedge i_clk or posedge i_reset) begin
				if (i_reset) begin
					sreq[s].valid <= 1'b0;
					sreq[s].write <= 1'b0;
					sreq[s].master <= '0;
					sreq[s].addr <= '0;
					sreq[s].wdata <= DATA_RESET;
				end else begin
					// Drop on done so the slave never sees a second beat
					sreq[s].valid <= (|grant[s]) && !i_srsp[s].done;
					sreq[s].write <= i_mreq[owner[s]].write;
					sreq[s].master <= MST_ID_W'(owner[s]);
					sreq[s].addr <= i_mreq[owner[s]].addr;
					sreq[s].wdata <= i_mreq[owner[s]].wdata & lane_mask(SLV_ID_W'(s));
				end
			end

			assign o_sreq[s] = sreq[s];
		end
	endgenerate

	// Master answers
	// A refusal answers one cycle after the request is seen; a granted
	// transfer answers one cycle after its slave reports done.
	generate
		for (genvar m = 0; m < NM; m++) begin : g_answer
			logic next_done;
			logic [DATA_W-1:0] next_rdata;

			// Collect the done of whichever slave holds this master
			always_comb begin
				next_done = 1'b0;
				next_rdata = DATA_RESET;
				for (int s = 0; s < NS; s++) begin
					if (grant[s][m] && i_srsp[s].done) begin
						next_done = 1'b1;
						next_rdata = i_srsp[s].rdata & lane_mask(SLV_ID_W'(s));
					end
				end
			end

			always_ff @(posedge i_clk or posedge i_reset) begin
				if (i_reset) begin
					mrsp[m].done <= 1'b0;
					mrsp[m].error <= 1'b0;
					mrsp[m].rdata <= DATA_RESET;
				end else if (refused[m] && !mrsp[m].done) begin
					mrsp[m].done <= 1'b1;
					mrsp[m].error <= 1'b1;
					mrsp[m].rdata <= DATA_RESET;
				end else begin
					mrsp[m].done <= next_done;
					mrsp[m].error <= 1'b0;
					mrsp[m].rdata <= next_done ? next_rdata : DATA_RESET;
				end
			end

			assign o_mrsp[m] = mrsp[m];
		end
	endgenerate
endmodule : sfb_switch_fabric

/* File: sim/sfb_switch_fabric_asserts.sv */
// Purpose: fabric port checks
// Assumes: one clock, async reset
// Notes: bound to the fabric top
`timescale 1ns/1ps
module sfb_switch_fabric_asserts #(
	parameter int NM = 11,
	parameter int NS = 10
) (
	// Clock, reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Watched ports
	input wire sfb_pkg::sfb_mreq_t [NM-1:0] i_mreq,
	input wire sfb_pkg::sfb_mrsp_t [NM-1:0] o_mrsp,
	input wire sfb_pkg::sfb_sreq_t [NS-1:0] o_sreq,
	input wire sfb_pkg::sfb_srsp_t [NS-1:0] i_srsp
);
	import sfb_pkg::*;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// Master answers
	for (genvar m = 0; m < NM; m++) begin : g_m
		err_done_a: assert property (
			o_mrsp[m].error |-> o_mrsp[m].done) else $error("bare error");
		bad_slave_a: assert property (
			i_mreq[m].valid && i_mreq[m].slave >= NS && !o_mrsp[m].done |=> o_mrsp[m].error)
			else $error("unknown slave taken");
	end
	// Slave paths; owner lags a cycle to tie answers back
	for (genvar s = 0; s < NS; s++) begin : g_s
		logic [MST_ID_W-1:0] owner;
		always_ff @(posedge i_clk) owner <= o_sreq[s].master;
		path_ok_a: assert property (
			o_sreq[s].valid |-> CONN_MATRIX[o_sreq[s].master][s] && i_mreq[o_sreq[s].master].slave == s)
			else $error("bad path");
		path_hold_a: assert property (
			o_sreq[s].valid && !i_srsp[s].done |=> o_sreq[s].valid && $stable(o_sreq[s].master))
			else $error("path dropped");
		answer_back_a: assert property (
			o_sreq[s].valid && i_srsp[s].done |=> o_mrsp[owner].done && !o_mrsp[owner].error)
			else $error("no answer");
		narrow_lane_a: assert property (
			o_sreq[s].valid && (s < 3 || s == 8) |-> o_sreq[s].wdata[127:64] == '0) else $error("wide data");
	end
	// Configuration endpoint
	cfg_lane_a: assert property (
		o_sreq[6].valid |-> o_sreq[6].wdata[127:32] == '0) else $error("wide cfg data");
	closed_win_a: assert property (
		o_sreq[6].valid |-> (o_sreq[6].addr & DEVCFG_MASK) != DEVCFG_BASE
		&& (o_sreq[6].addr & CLKGEN_MASK) != CLKGEN_BASE) else $error("closed window");
	cover property (o_sreq[0].valid && o_sreq[7].valid);
	cover property (o_mrsp[0].error);
	cover property (o_sreq[6].valid && i_srsp[6].done);
endmodule : sfb_switch_fabric_asserts

bind sfb_switch_fabric sfb_switch_fabric_asserts #(.NM(NM), .NS(NS)) i_chk (.i_clk(i_clk), .i_reset(i_reset),
	.i_mreq(i_mreq), .o_mrsp(o_mrsp), .o_sreq(o_sreq), .i_srsp(i_srsp));

/* File: sim/sfb_slave_model.sv */
// Purpose: slave peripherals behind the fabric
// Assumes: one answer per granted request
// Notes: wait follows i_delay
`timescale 1ns/1ps
module sfb_slave_model (
	// Clock, reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Answer wait
	input wire logic [1:0] i_delay,
	// Fabric side
	input wire sfb_pkg::sfb_sreq_t [9:0] i_sreq,
	output sfb_pkg::sfb_srsp_t [9:0] o_srsp
);
	import sfb_pkg::*;
	logic [9:0] armed;
	logic [1:0] cnt [10];
	// slaves only answer
	// Idle data inverts so stale data never looks valid
	always @(posedge i_clk or posedge i_reset) begin
		for (int s = 0; s < 10; s++) begin
			o_srsp[s].done <= 1'b0;
			o_srsp[s].rdata <= i_reset ? '0 : ~o_srsp[s].rdata;
			cnt[s] <= cnt[s] + 2'h1;
			if (i_reset || !i_sreq[s].valid) begin
				armed[s] <= 1'b1;
				cnt[s] <= 2'h0;
			end else if (armed[s] && cnt[s] == i_delay) begin
				o_srsp[s].done <= 1'b1;
				o_srsp[s].rdata <= {4{i_sreq[s].addr ^ 32'hA5A5_A5A5}};
				armed[s] <= 1'b0;
			end
		end
	end
endmodule : sfb_slave_model

/* File: sim/test_sfb_switch_fabric.sv */
// Purpose: self-checking fabric bench
// Assumes: slave model answers each grant
// Notes: allowed paths kept as a table here
`timescale 1ns/1ps
module test_sfb_switch_fabric;
	import sfb_pkg::*;
	logic i_clk;
	logic i_reset;
	logic [1:0] dly = 2'h0;
	sfb_mreq_t [10:0] i_mreq;
	sfb_mrsp_t [10:0] o_mrsp;
	sfb_sreq_t [9:0] o_sreq;
	sfb_srsp_t [9:0] i_srsp;
	sfb_sreq_t last [10];
	int mismatches = 0;
	int cmp_count = 0;
	// Set by a timed-out wait; later transfers are skipped
	bit abort = 1'b0;
	int hits [10] = '{default: 0};
	logic [3:0] order [$];
	// Allowed slaves per master, slave 0 first
	string tbl [11] = '{"YYYNNNNYYY", "NNYYYNNYYY", "NNNYYYYYYY", "NNNNNYYYYY", "NNNNNNYYYY", "NNNNNNYYYY",
		"NNNNNNNYYY", "NNNNNNYYYY", "NNNNNNYYYY", "NNNNNNYYYY", "YYYYYYNYYN"};
	sfb_switch_fabric i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_mreq(i_mreq), .o_mrsp(o_mrsp),
		.o_sreq(o_sreq), .i_srsp(i_srsp));
	sfb_slave_model i_slv (.i_clk(i_clk), .i_reset(i_reset), .i_delay(dly), .i_sreq(o_sreq), .o_srsp(i_srsp));
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	// Slave delay redrawn 0 to 3 every cycle, so stalls can exceed 3 cycles
	always @(posedge i_clk) dly <= 2'($urandom);
	// Log finished slave transfers
	always @(posedge i_clk) begin
		for (int s = 0; s < 10; s++) begin
			if (o_sreq[s].valid === 1'b1 && i_srsp[s].done === 1'b1) begin
				hits[s]++;
				last[s] = o_sreq[s];
				if (s > 5 && s < 8) order.push_back(o_sreq[s].master);
			end
		end
	end
	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task give_verdict;
		$display("compares=%0d mismatches=%0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	function automatic logic [127:0] lane(input int s, input logic [127:0] v);
		if (s == 6) return {96'h0, v[31:0]};
		return (s < 3 || s == 8) ? {64'h0, v[63:0]} : v;
	endfunction : lane
	// One request, held until answered
	task automatic xfer(input int m, input int s, input logic [31:0] a, input logic [2:0] p);
		logic [127:0] wd;
		int h;
		bit ok;
		bit w;
		if (abort) return;
		wd = {$urandom, $urandom, $urandom, $urandom};
		w = wd[0];
		ok = s < 10 && tbl[m][s] == "Y" && !(s == 6 && ((a & 32'hFFFF_FC00) inside {32'h0288_0800, 32'h0290_0000}));
		h = s < 10 ? hits[s] : 0;
		@(posedge i_clk);
		i_mreq[m] <= '{1'b1, w, s[3:0], p, a, wd};
		// Bound covers queued contenders behind random slave stalls
		for (int n = 0; n <= 200; n++) begin
			if (n == 200) begin
				check(1'b0, 1'b1);
				abort = 1'b1;
				return;
			end
			@(negedge i_clk);
			if (o_mrsp[m].done === 1'b1) break;
		end
		check(o_mrsp[m].error, !ok);
		if (ok && !w) check(o_mrsp[m].rdata, lane(s, {4{a ^ 32'hA5A5_A5A5}}));
		if (ok) check({last[s].master, last[s].addr, last[s].write}, {m[3:0], a, w});
		if (ok) check(last[s].wdata, lane(s, wd));
		if (!ok && s < 10) check(hits[s], h);
		@(posedge i_clk);
		i_mreq[m].valid <= 1'b0;
	endtask : xfer
	initial begin
		void'($urandom(67));
		i_reset = 1'b1;
		i_mreq = '0;
		repeat (3) @(posedge i_clk);
		i_reset <= 1'b0;
		repeat (2) @(posedge i_clk);
		// Every master to every slave, two unknown, closed windows
		for (int m = 0; m < 11; m++) begin
			for (int s = 0; s < 12; s++) xfer(m, s, 32'h1000_0000 + $urandom_range(0, 32'hFFFF), 3'($urandom));
			xfer(m, 6, 32'h0288_0910, 3'h0);
			xfer(m, 6, 32'h0290_0004, 3'h0);
		end
		// Memory race beside an unrelated path
		order.delete();
		fork
			xfer(0, 7, 32'h1000_0040, 3'h3);
			xfer(6, 7, 32'h1000_0080, 3'h1);
			xfer(7, 7, 32'h1000_00C0, 3'h5);
			xfer(10, 0, 32'h1000_0100, 3'h7);
		join
		check({order[0], order[1], order[2]}, {4'h6, 4'h0, 4'h7});
		// Tie on the configuration endpoint
		order.delete();
		fork
			xfer(3, 6, 32'h1000_0200, 3'h2);
			xfer(4, 6, 32'h1000_0204, 3'h0);
			xfer(5, 6, 32'h1000_0208, 3'h2);
		join
		check({order[0], order[1], order[2]}, {4'h4, 4'h5, 4'h3});
		give_verdict();
	end
endmodule : test_sfb_switch_fabric
